// ---- logic/pmd_pkg.sv ----
package pmd_pkg;
    // Command codes
    localparam logic [7:0] PMD_CMD_ROM_MODE = 8'hD9;
    localparam logic [7:0] PMD_CMD_SHARE = 8'hDA;
    localparam logic [7:0] PMD_CMD_RAMP = 8'hDB;
    localparam logic [7:0] PMD_CMD_TEMP_SEL = 8'hDC;
    localparam logic [7:0] PMD_CMD_VIN_OFS = 8'hDD;
    localparam logic [7:0] PMD_CMD_VOUT_TRIM = 8'hDE;
    localparam logic [7:0] PMD_CMD_STATUS = 8'hDF;
    // Block lengths in bytes
    localparam logic [5:0] PMD_LEN_ROM = 6'h04;
    localparam logic [5:0] PMD_LEN_SHARE = 6'h08;
    localparam logic [5:0] PMD_LEN_RECORD = 6'h20;
    localparam logic [5:0] PMD_LEN_BYTE = 6'h01;
    localparam logic [5:0] PMD_LEN_VIN = 6'h04;
    localparam logic [5:0] PMD_LEN_WORD = 6'h02;
    // Field layout
    localparam int PMD_THR_W = 48;
    localparam int PMD_SHARE_EN_BIT = 56;
    localparam int PMD_TEMP_SEL_BIT = 0;
    localparam int PMD_PAIRS = 15;
    localparam int PMD_VIN0_LSB = 16;
    localparam int PMD_VOUT0_LSB = 24;
    localparam int PMD_PAIR_STEP = 16;
    localparam int PMD_STATUS_WORDS = 16;
    localparam int PMD_VIN_ON_LSB = 16;
    // Reset values
    localparam logic [63:0] PMD_SHARE_RST = 64'h0;
    localparam logic [7:0] PMD_TEMP_RST = 8'h00;
    // Timing: status snapshot interval
    localparam longint PMD_SNAP_S = 8;
    localparam longint PMD_CLK_HZ = 100000000;
    localparam longint PMD_SNAP_CYC = PMD_SNAP_S * PMD_CLK_HZ;
    typedef enum logic [1:0] {PMD_RAMP_IDLE, PMD_RAMP_RUN, PMD_RAMP_DONE} pmd_ramp_t;
endpackage

// ---- logic/pmd_interval.sv ----
`timescale 1ns/1ps
`default_nettype none
// Periodic tick generator
module pmd_interval #(
    parameter int unsigned CNT_W = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [CNT_W-1:0] period,
    output logic tick
);
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge ref_clk)
    begin
        // Preload one: first tick lands period-1 cycles after run rises, later ticks every period cycles
        if (rst || !run)
        begin
            cnt_reg <= CNT_W'(1'b1);
            tick <= 1'b0;
        end
        else if (cnt_reg >= period - 1'b1)
        begin
            cnt_reg <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- logic/pmd_cmd_set.sv ----
// Summary of operation
// [R1] A four-byte block write to the ROM-mode command switches the device into boot-ROM mode.
// [R2] The current-share block is eight bytes, read/write, with the threshold in bits 47:0.
// [R3] Bit 56 of the current-share block enables active current sharing when set.
// [R4] A block read of the ramp record returns 32 bytes.
// [R5] Fifteen Vin/Vout byte pairs are taken during the ramp, pair n at bits 16n+23:16n+16 and 16n+31:16n+24.
// [R6] Just before the ramp the record counter in bits 15:0 is set to the snapshot count plus one.
// [R7] Only the first ramp after power-up is recorded.
// [R8] The ramp record is cleared after a successful ramp-up.
// [R9] Bit 0 of the temperature select byte picks the internal (0) or external (1) sensor.
// [R10] A read-only four-byte block holds the turn-on offset in 31:16 and turn-off in 15:0.
// [R11] A word read returns the signed output-voltage trim in bits 15:0.
// [R12] A block read returns sixteen status words, word 0 lowest.
// [R13] After the ramp one status word is stored every 8 s for the first 128 s.
// [R14] Unused bits of the current-share block read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module pmd_cmd_set
    import pmd_pkg::*;
#(
    parameter longint SNAP_CYCLES = pmd_pkg::PMD_SNAP_CYC,
    parameter int unsigned RAMP_CNT_W = 24
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Byte-level command port from the bus engine
    input wire logic [7:0] cmd_code,
    input wire logic wr_start,
    input wire logic wr_byte_valid,
    input wire logic [7:0] wr_byte,
    input wire logic wr_done,
    input wire logic rd_start,
    input wire logic rd_byte_req,
    output logic [7:0] rd_byte,
    output logic [5:0] rd_len,
    output logic cmd_ok,
    // Power stage signals
    input wire logic ramp_active,
    input wire logic ramp_good,
    input wire logic [7:0] vin_sample,
    input wire logic [7:0] vout_sample,
    input wire logic [RAMP_CNT_W-1:0] ramp_interval,
    input wire logic [15:0] status_word,
    input wire logic [15:0] vin_ofs_on,
    input wire logic [15:0] vin_ofs_off,
    input wire logic [15:0] vout_trim,
    // Control outputs
    output logic rom_mode,
    output logic share_en,
    output logic [47:0] share_threshold,
    output logic temp_external
);
    import pmd_pkg::*;

    // Refuse counts the tick counter or ramp timer cannot hold
    if (SNAP_CYCLES < 2 || SNAP_CYCLES >= 64'h0000_0100_0000_0000
        || RAMP_CNT_W < 2 || RAMP_CNT_W > 32)
    begin : g_param_check
        $error("pmd_cmd_set: bad parameter");
    end

    ////////////////////////////////////////////////////////////////////
    // Synchronise power-stage levels
    logic ramp_s1_reg, ramp_s2_reg, good_s1_reg, good_s2_reg, ramp_d_reg;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ramp_s1_reg <= 1'b0;
            ramp_s2_reg <= 1'b0;
            good_s1_reg <= 1'b0;
            good_s2_reg <= 1'b0;
            ramp_d_reg <= 1'b0;
        end
        else
        begin
            ramp_s1_reg <= ramp_active;
            ramp_s2_reg <= ramp_s1_reg;
            good_s1_reg <= ramp_good;
            good_s2_reg <= good_s1_reg;
            ramp_d_reg <= ramp_s2_reg;
        end
    end
    logic ramp_rise, ramp_fall;
    assign ramp_rise = ramp_s2_reg && !ramp_d_reg;
    assign ramp_fall = !ramp_s2_reg && ramp_d_reg;

    ////////////////////////////////////////////////////////////////////
    // Write path: byte assembly
    logic [63:0] wbuf_reg;
    logic [5:0] wcnt_reg;
    always_ff @(posedge ref_clk)
    begin
        if (rst || wr_start)
        begin
            wbuf_reg <= '0;
            wcnt_reg <= '0;
        end
        else if (wr_byte_valid && wcnt_reg < PMD_LEN_SHARE)
        begin
            wbuf_reg[wcnt_reg[2:0]*8 +: 8] <= wr_byte;
            wcnt_reg <= wcnt_reg + 6'h01;
        end
    end

    logic wr_rom, wr_share, wr_temp;
    assign wr_rom = wr_done && cmd_code == PMD_CMD_ROM_MODE && wcnt_reg == PMD_LEN_ROM;
    assign wr_share = wr_done && cmd_code == PMD_CMD_SHARE && wcnt_reg == PMD_LEN_SHARE;
    assign wr_temp = wr_done && cmd_code == PMD_CMD_TEMP_SEL && wcnt_reg == PMD_LEN_BYTE;

    ////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rom_mode <= 1'b0;
        else if (wr_rom)
            rom_mode <= 1'b1; // R1
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            share_threshold <= PMD_SHARE_RST[47:0];
            share_en <= PMD_SHARE_RST[PMD_SHARE_EN_BIT];
        end
        else if (wr_share)
        begin
            share_threshold <= wbuf_reg[PMD_THR_W-1:0]; // R2
            share_en <= wbuf_reg[PMD_SHARE_EN_BIT]; // R3
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            temp_external <= PMD_TEMP_RST[0];
        else if (wr_temp)
            temp_external <= wbuf_reg[PMD_TEMP_SEL_BIT]; // R9
    end

    ////////////////////////////////////////////////////////////////////
    // Ramp recorder
    pmd_ramp_t rstate_reg;
    logic [255:0] ramp_rec_reg;
    logic [3:0] pair_reg;
    logic [RAMP_CNT_W-1:0] rtimer_reg;
    logic [4:0] snap_cnt_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rstate_reg <= PMD_RAMP_IDLE;
        else
        begin
            unique case (rstate_reg)
                PMD_RAMP_IDLE:
                    if (ramp_rise)
                        rstate_reg <= PMD_RAMP_RUN;
                PMD_RAMP_RUN:
                    if (ramp_fall)
                        rstate_reg <= PMD_RAMP_DONE;
                PMD_RAMP_DONE:
                    rstate_reg <= PMD_RAMP_DONE; // R7
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ramp_rec_reg <= '0;
            pair_reg <= '0;
            rtimer_reg <= '0;
        end
        else if (rstate_reg == PMD_RAMP_IDLE && ramp_rise)
        begin
            ramp_rec_reg <= '0;
            ramp_rec_reg[15:0] <= 16'(snap_cnt_reg) + 16'h0001; // R6
            pair_reg <= '0;
            rtimer_reg <= '0;
        end
        else if (rstate_reg == PMD_RAMP_RUN)
        begin
            if (ramp_fall && good_s2_reg)
                ramp_rec_reg <= '0; // R8
            else if (pair_reg < 4'(PMD_PAIRS))
            begin
                if (rtimer_reg == '0)
                begin
                    ramp_rec_reg[PMD_VIN0_LSB + pair_reg*PMD_PAIR_STEP +: 8] <= vin_sample; // R5
                    ramp_rec_reg[PMD_VOUT0_LSB + pair_reg*PMD_PAIR_STEP +: 8] <= vout_sample; // R5
                    pair_reg <= pair_reg + 4'h1;
                    rtimer_reg <= ramp_interval;
                end
                else
                    rtimer_reg <= rtimer_reg - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status recorder
    logic [255:0] stat_rec_reg;
    logic stat_run_reg;
    logic snap_tick;

    pmd_interval #(
        .CNT_W(40)
    ) u_snap (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(stat_run_reg),
        .period(40'(SNAP_CYCLES)),
        .tick(snap_tick)
    );

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stat_run_reg <= 1'b0;
            snap_cnt_reg <= '0;
            stat_rec_reg <= '0;
        end
        else if (rstate_reg == PMD_RAMP_RUN && ramp_fall)
        begin
            stat_run_reg <= 1'b1; // R13
            stat_rec_reg[15:0] <= status_word;
            snap_cnt_reg <= 5'h01;
        end
        else if (stat_run_reg && snap_tick)
        begin
            stat_rec_reg[snap_cnt_reg[3:0]*16 +: 16] <= status_word; // R12
            snap_cnt_reg <= snap_cnt_reg + 5'h01;
            if (snap_cnt_reg == 5'(PMD_STATUS_WORDS - 1))
                stat_run_reg <= 1'b0; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    logic [255:0] rsrc_reg;
    logic [4:0] ridx_reg;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rsrc_reg <= '0;
            rd_len <= '0;
            cmd_ok <= 1'b0;
            ridx_reg <= '0;
            rd_byte <= '0;
        end
        else if (rd_start)
        begin
            ridx_reg <= '0;
            rd_byte <= '0;
            cmd_ok <= 1'b1;
            rsrc_reg <= '0;
            unique case (cmd_code)
                PMD_CMD_SHARE:
                begin
                    rsrc_reg[63:0] <= {7'h00, share_en, 8'h00, share_threshold}; // R14
                    rd_len <= PMD_LEN_SHARE;
                end
                PMD_CMD_RAMP:
                begin
                    rsrc_reg <= ramp_rec_reg; // R4
                    rd_len <= PMD_LEN_RECORD;
                end
                PMD_CMD_TEMP_SEL:
                begin
                    rsrc_reg[0] <= temp_external;
                    rd_len <= PMD_LEN_BYTE;
                end
                PMD_CMD_VIN_OFS:
                begin
                    rsrc_reg[31:0] <= {vin_ofs_on, vin_ofs_off}; // R10
                    rd_len <= PMD_LEN_VIN;
                end
                PMD_CMD_VOUT_TRIM:
                begin
                    rsrc_reg[15:0] <= vout_trim; // R11
                    rd_len <= PMD_LEN_WORD;
                end
                PMD_CMD_STATUS:
                begin
                    rsrc_reg <= stat_rec_reg; // R12
                    rd_len <= PMD_LEN_RECORD;
                end
                default:
                begin
                    rd_len <= '0;
                    cmd_ok <= 1'b0;
                end
            endcase
        end
        else if (rd_byte_req)
        begin
            rd_byte <= rsrc_reg[ridx_reg*8 +: 8];
            ridx_reg <= ridx_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    rom_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
        $past(wr_rom) |-> rom_mode) else $error("rom mode not entered"); // R1
    rom_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        rom_mode |=> rom_mode) else $error("rom mode dropped"); // R1
    share_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_share |=> share_threshold == $past(wbuf_reg[47:0])) else $error("threshold"); // R2
    share_en_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_share |=> share_en == $past(wbuf_reg[56])) else $error("share enable"); // R3
    temp_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_temp |=> temp_external == $past(wbuf_reg[0])) else $error("temp select"); // R9
    first_ramp_a: assert property (@(posedge ref_clk) disable iff (rst)
        rstate_reg == PMD_RAMP_DONE |=> rstate_reg == PMD_RAMP_DONE && $stable(ramp_rec_reg))
        else $error("ramp rearm"); // R7
    ramp_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        rstate_reg == PMD_RAMP_RUN && ramp_fall && good_s2_reg |=> ramp_rec_reg == '0)
        else $error("ramp not cleared"); // R8
    ramp_cnt_a: assert property (@(posedge ref_clk) disable iff (rst)
        rstate_reg == PMD_RAMP_IDLE && ramp_rise |=> ramp_rec_reg[15:0] == 16'($past(snap_cnt_reg)) + 16'h0001)
        else $error("record counter"); // R6
    pair_lim_a: assert property (@(posedge ref_clk) disable iff (rst)
        rstate_reg == PMD_RAMP_RUN && pair_reg == 4'(PMD_PAIRS) && !ramp_fall |=> $stable(ramp_rec_reg))
        else $error("pair overflow"); // R5
    pair_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        rstate_reg == PMD_RAMP_RUN && pair_reg == 4'h0 && rtimer_reg == '0 && !ramp_fall
        |=> ramp_rec_reg[23:16] == $past(vin_sample) && ramp_rec_reg[31:24] == $past(vout_sample))
        else $error("pair 0 placement"); // R5
    stat_first_a: assert property (@(posedge ref_clk) disable iff (rst)
        rstate_reg == PMD_RAMP_RUN && ramp_fall |=> stat_rec_reg[15:0] == $past(status_word))
        else $error("status word 0"); // R13
    stat_lim_a: assert property (@(posedge ref_clk) disable iff (rst)
        snap_cnt_reg <= 5'(PMD_STATUS_WORDS)) else $error("status overflow"); // R13
    share_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_start && cmd_code == PMD_CMD_SHARE |=> rsrc_reg[63:57] == '0 && rsrc_reg[55:48] == '0)
        else $error("reserved bits"); // R14
endmodule
`default_nettype wire

// ---- dv/pmd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmd_host_model (
    // Clock
    input wire logic ref_clk,
    // Command port toward the device
    output logic [7:0] cmd_code,
    output logic wr_start,
    output logic wr_byte_valid,
    output logic [7:0] wr_byte,
    output logic wr_done,
    output logic rd_start,
    output logic rd_byte_req,
    input wire logic [7:0] rd_byte,
    input wire logic [5:0] rd_len,
    input wire logic cmd_ok
);
    initial
    begin
        cmd_code = 8'h00;
        wr_start = 1'b0;
        wr_byte_valid = 1'b0;
        wr_byte = 8'hA5;
        wr_done = 1'b0;
        rd_start = 1'b0;
        rd_byte_req = 1'b0;
    end

    ////////////////////////////////////////
    // Block write, byte 0 first
    task automatic write_blk(input logic [7:0] code, input int n, input logic [255:0] data);
        @(posedge ref_clk);
        cmd_code <= code;
        wr_start <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            wr_start <= 1'b0;
            wr_byte_valid <= 1'b1;
            wr_byte <= data[8*i +: 8];
        end
        @(posedge ref_clk);
        wr_start <= 1'b0;
        wr_byte_valid <= 1'b0;
        // Released data line does not keep its value
        wr_byte <= ~wr_byte;
        wr_done <= 1'b1;
        @(posedge ref_clk);
        wr_done <= 1'b0;
    endtask

    ////////////////////////////////////////
    // Block read, byte 0 first
    task automatic read_blk(input logic [7:0] code, input int n, output logic [255:0] data,
        output logic [5:0] len, output logic ok);
        data = '0;
        @(posedge ref_clk);
        cmd_code <= code;
        rd_start <= 1'b1;
        @(posedge ref_clk);
        rd_start <= 1'b0;
        rd_byte_req <= 1'b1;
        @(posedge ref_clk);
        len = rd_len;
        ok = cmd_ok;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            data[8*i +: 8] = rd_byte;
            if (i + 2 >= n)
                rd_byte_req <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_pmd_cmd_set.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pmd_cmd_set;
    import pmd_pkg::*;
    logic ref_clk;
    logic rst;
    logic [7:0] cmd_code;
    logic wr_start;
    logic wr_byte_valid;
    logic [7:0] wr_byte;
    logic wr_done;
    logic rd_start;
    logic rd_byte_req;
    logic [7:0] rd_byte;
    logic [5:0] rd_len;
    logic cmd_ok;
    logic ramp_active;
    logic ramp_good;
    logic [7:0] vin_sample;
    logic [7:0] vout_sample;
    logic [23:0] ramp_interval;
    logic [15:0] status_word;
    logic [15:0] vin_ofs_on;
    logic [15:0] vin_ofs_off;
    logic [15:0] vout_trim;
    logic rom_mode;
    logic share_en;
    logic [47:0] share_threshold;
    logic temp_external;
    int err_total = 0;
    int n_tests = 0;
    logic [255:0] st_exp;

    pmd_cmd_set #(.SNAP_CYCLES(20)) pmd_cmd_set_inst (.ref_clk(ref_clk), .rst(rst),
        .cmd_code(cmd_code), .wr_start(wr_start), .wr_byte_valid(wr_byte_valid),
        .wr_byte(wr_byte), .wr_done(wr_done), .rd_start(rd_start), .rd_byte_req(rd_byte_req),
        .rd_byte(rd_byte), .rd_len(rd_len), .cmd_ok(cmd_ok), .ramp_active(ramp_active),
        .ramp_good(ramp_good), .vin_sample(vin_sample), .vout_sample(vout_sample),
        .ramp_interval(ramp_interval), .status_word(status_word), .vin_ofs_on(vin_ofs_on),
        .vin_ofs_off(vin_ofs_off), .vout_trim(vout_trim), .rom_mode(rom_mode),
        .share_en(share_en), .share_threshold(share_threshold), .temp_external(temp_external));

    pmd_host_model pmd_host_model_inst (.ref_clk(ref_clk), .cmd_code(cmd_code),
        .wr_start(wr_start), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
        .wr_done(wr_done), .rd_start(rd_start), .rd_byte_req(rd_byte_req), .rd_byte(rd_byte),
        .rd_len(rd_len), .cmd_ok(cmd_ok));

    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] code, input int n, input logic [255:0] exp,
        input logic [5:0] elen, input logic eok);
        logic [255:0] d;
        logic [5:0] l;
        logic o;
        pmd_host_model_inst.read_blk(code, n, d, l, o);
        chk(d, exp);
        chk(o, eok);
        if (eok)
            chk(l, elen);
    endtask

    task automatic wr(input logic [7:0] code, input int n, input logic [255:0] data);
        pmd_host_model_inst.write_blk(code, n, data);
        repeat (2) @(posedge ref_clk);
    endtask

    // Ramp of 120 cycles with steady samples
    task automatic ramp(input logic [7:0] vi, input logic [7:0] vo, input logic good);
        @(posedge ref_clk);
        vin_sample <= vi;
        vout_sample <= vo;
        ramp_good <= good;
        ramp_active <= 1'b1;
        repeat (120) @(posedge ref_clk);
        ramp_active <= 1'b0;
    endtask

    ////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end

    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        ramp_active = 1'b0;
        ramp_good = 1'b0;
        vin_sample = 8'h00;
        vout_sample = 8'h00;
        ramp_interval = 24'h000004;
        status_word = 16'h5555;
        vin_ofs_on = 16'h1234;
        vin_ofs_off = 16'hABCD;
        vout_trim = 16'hF00D;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk({rom_mode, share_en, share_threshold, temp_external}, '0);
        rd_chk(PMD_CMD_SHARE, 8, '0, PMD_LEN_SHARE, 1'b1);
        wr(PMD_CMD_SHARE, 8, 64'hFFFF_0123_4567_89AB);
        chk({share_en, share_threshold}, {1'b1, 48'h0123_4567_89AB});
        rd_chk(PMD_CMD_SHARE, 8, 64'h0100_0123_4567_89AB, PMD_LEN_SHARE, 1'b1);
        wr(PMD_CMD_SHARE, 7, '0);
        chk(share_en, 1'b1);
        wr(PMD_CMD_SHARE, 8, 64'hFEFF_FFFF_FFFF_FFFF);
        chk({share_en, share_threshold}, {1'b0, 48'hFFFF_FFFF_FFFF});
        rd_chk(PMD_CMD_SHARE, 8, 64'h0000_FFFF_FFFF_FFFF, PMD_LEN_SHARE, 1'b1);
        for (int v = 1; v >= 0; v--)
        begin
            wr(PMD_CMD_TEMP_SEL, 1, v);
            chk(temp_external, v);
            rd_chk(PMD_CMD_TEMP_SEL, 1, v, PMD_LEN_BYTE, 1'b1);
        end
        wr(PMD_CMD_ROM_MODE, 3, 32'h524F_4D21);
        chk(rom_mode, 1'b0);
        wr(PMD_CMD_ROM_MODE, 4, 32'h524F_4D21);
        chk(rom_mode, 1'b1);
        rd_chk(PMD_CMD_VIN_OFS, 4, 32'h1234_ABCD, PMD_LEN_VIN, 1'b1);
        rd_chk(PMD_CMD_VOUT_TRIM, 2, 16'hF00D, PMD_LEN_WORD, 1'b1);
        rd_chk(8'hE0, 1, '0, 6'h00, 1'b0);
        // Failed ramp keeps its record; later ramps ignored
        ramp(8'h30, 8'h0A, 1'b0);
        repeat (10) @(posedge ref_clk);
        rd_chk(PMD_CMD_RAMP, 32, {{15{8'h0A, 8'h30}}, 16'h0001}, PMD_LEN_RECORD, 1'b1);
        ramp(8'h55, 8'h22, 1'b0);
        repeat (10) @(posedge ref_clk);
        rd_chk(PMD_CMD_RAMP, 32, {{15{8'h0A, 8'h30}}, 16'h0001}, PMD_LEN_RECORD, 1'b1);
        // Power cycle, then a good ramp and the status recording
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        status_word <= 16'hA000;
        ramp(8'h40, 8'h0B, 1'b1);
        repeat (13) @(posedge ref_clk);
        for (int k = 1; k < 20; k++)
        begin
            status_word <= 16'hA000 + 16'(k);
            repeat (20) @(posedge ref_clk);
        end
        rd_chk(PMD_CMD_RAMP, 32, '0, PMD_LEN_RECORD, 1'b1);
        for (int k = 0; k < 16; k++)
            st_exp[16*k +: 16] = 16'hA000 + 16'(k);
        rd_chk(PMD_CMD_STATUS, 32, st_exp, PMD_LEN_RECORD, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
